// [hw/camds_defines.svh]
`ifndef CAMDS_DEFINES_SVH
`define CAMDS_DEFINES_SVH

// register byte offsets
`define CAMDS_ADR_CTRL       8'h00
`define CAMDS_ADR_MEM_OP     8'h04
`define CAMDS_ADR_MEM_RES    8'h08
`define CAMDS_ADR_MEM_RES_HI 8'h0c
`define CAMDS_ADR_STATUS     8'h10
`define CAMDS_ADR_STATE      8'h14
// working registers at 0x40 + 4*n, selected by address bits 7:6
`define CAMDS_WREG_WIN       2'h1

// status word bit positions
`define CAMDS_SW_DIGIT_CARRY 8
`define CAMDS_SW_N           3
`define CAMDS_SW_OVERFLOW    2
`define CAMDS_SW_Z           1
`define CAMDS_SW_C           0

// reset values
`define CAMDS_RST_WORD       16'h0000
`define CAMDS_RST_CTL        29'h0000000

// timing counts
`define CAMDS_DIV_ITERS      4'hf
`define CAMDS_DIV_CYCLES     19

`endif

// [hw/camds_div.sv]
`include "camds_defines.svh"
`default_nettype none
module camds_div
  import camds_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // request
  input  wire logic        start_i,
  input  wire logic        sign_i,
  input  wire logic [31:0] dvd_i,
  input  wire logic [15:0] dvs_i,
  // answer
  output logic             done_o,
  output logic             ovf_o,
  output logic      [15:0] quo_o,
  output logic      [15:0] rem_o
);

  camds_dphase_t phase;
  logic [31:0]   dvd_raw;
  logic [15:0]   dvs_raw;
  logic          sgn;
  logic          negq;
  logic          negr;
  logic [17:0]   p;
  logic [15:0]   r;
  logic [15:0]   d;
  logic [3:0]    cnt;
  logic [31:0]   a32;
  logic [15:0]   dmag;
  logic [17:0]   sh;
  logic [17:0]   np;

  always_comb begin
    a32  = (sgn && dvd_raw[31]) ? (~dvd_raw + 32'h00000001) : dvd_raw;
    dmag = (sgn && dvs_raw[15]) ? (~dvs_raw + 16'h0001) : dvs_raw;
    sh   = {p[16:0], r[15]};
    np   = p[17] ? (sh + {2'h0, d}) : (sh - {2'h0, d});
  end

  // non-restoring divide on magnitudes, signs fixed at the end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase   <= dv_idle;
      dvd_raw <= 32'h00000000;
      dvs_raw <= 16'h0000;
      sgn     <= 1'b0;
      negq    <= 1'b0;
      negr    <= 1'b0;
      p       <= 18'h00000;
      r       <= 16'h0000;
      d       <= 16'h0000;
      cnt     <= 4'h0;
      done_o  <= 1'b0;
      ovf_o   <= 1'b0;
      quo_o   <= 16'h0000;
      rem_o   <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      case (phase)
        dv_idle: begin
          if (start_i) begin
            dvd_raw <= dvd_i;
            dvs_raw <= dvs_i;
            sgn     <= sign_i;
            negq    <= sign_i & (dvd_i[31] ^ dvs_i[15]);
            negr    <= sign_i & dvd_i[31];
            phase   <= dv_abs;
          end
        end
        dv_abs: begin
          p     <= {2'h0, a32[31:16]};
          r     <= a32[15:0];
          d     <= dmag;
          ovf_o <= (dmag == 16'h0000) || (a32[31:16] >= dmag);
          cnt   <= 4'h0;
          phase <= dv_iter;
        end
        dv_iter: begin
          p   <= np;
          r   <= {r[14:0], ~np[17]};
          cnt <= cnt + 4'h1;
          if (cnt == `CAMDS_DIV_ITERS) begin
            phase <= dv_fix;
          end
        end
        dv_fix: begin
          if (p[17]) begin
            p <= p + {2'h0, d};
          end
          phase <= dv_sign;
        end
        dv_sign: begin
          quo_o  <= negq ? (~r + 16'h0001) : r;
          rem_o  <= negr ? (~p[15:0] + 16'h0001) : p[15:0];
          ovf_o  <= ovf_o | (sgn & r[15] & ~(negq & (r == 16'h8000)));
          done_o <= 1'b1;
          phase  <= dv_idle;
        end
        default: begin
          phase <= dv_idle;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [hw/camds_mul.sv]
`default_nettype none
module camds_mul
  import camds_pkg::*;
(
  // operands
  input  wire logic [15:0]  a_i,
  input  wire logic [15:0]  b_i,
  input  wire logic [4:0]   lit_i,
  input  wire camds_mmode_t mode_i,
  // product
  output logic      [31:0]  prod_o
);

  logic        [16:0] x;
  logic        [16:0] y;
  logic signed [33:0] p34;

  // one 17x17 signed array covers every sign mix
  always_comb begin
    case (mode_i)
      mul_ss: begin
        x = {a_i[15], a_i};
        y = {b_i[15], b_i};
      end
      mul_s_lit: begin
        x = {a_i[15], a_i};
        y = {12'h000, lit_i};
      end
      mul_u_lit: begin
        x = {1'b0, a_i};
        y = {12'h000, lit_i};
      end
      mul_us: begin
        x = {1'b0, a_i};
        y = {b_i[15], b_i};
      end
      mul_ub: begin
        x = {9'h000, a_i[7:0]};
        y = {9'h000, b_i[7:0]};
      end
      default: begin
        x = {1'b0, a_i};
        y = {1'b0, b_i};
      end
    endcase
    p34    = $signed(x) * $signed(y);
    prod_o = p34[31:0];
  end

endmodule
`default_nettype wire

// [hw/camds_pkg.sv]
`default_nettype none
package camds_pkg;

  typedef enum logic [3:0] {
    op_add, op_addc, op_sub, op_subb, op_and, op_ior, op_xor,
    left_shift_op, arith_right_shift_op, logical_right_shift_op, op_mul, op_div
  } camds_op_t;

  typedef enum logic [2:0] {
    mul_ss, mul_uu, mul_s_lit, mul_u_lit, mul_us, mul_ub
  } camds_mmode_t;

  typedef enum logic [1:0] {
    st_idle, st_exec, st_divw
  } camds_state_t;

  typedef enum logic [2:0] {
    dv_idle, dv_abs, dv_iter, dv_fix, dv_sign
  } camds_dphase_t;

  // control word as written by software, bit 28 down to bit 0
  typedef struct packed {
    logic         div32;
    logic [3:0]   d_idx;
    logic [3:0]   b_idx;
    logic [3:0]   a_idx;
    logic         dsign;
    logic         d_mem;
    logic         a_mem;
    logic [4:0]   lit;
    camds_mmode_t mmode;
    logic         byte_sz;
    camds_op_t    op;
  } camds_ctl_t;

  typedef struct packed {
    logic digit_carry_flag;
    logic n;
    logic overflow_flag;
    logic z;
    logic c;
  } camds_flags_t;

endpackage
`default_nettype wire

// [hw/camds_top.sv]
// Contract
// - sixteen-bit datapath doing add, subtract, shifts and bitwise logic.
// - arithmetic treats operands and results as two's complement.
// - operations update carry, zero, negative, overflow and digit-carry in status word.
// - on subtraction carry means no borrow, digit carry means no digit borrow.
// - add, subtract, logic and shift operations run at byte or word width per size mode; divide ignores it.
// - operands from working registers or memory; results to either, per mode.
// - one 17x17 multiplier array handles signed, unsigned and mixed products.
// - multiply modes ss, uu, signed x lit5, unsigned x lit5, us, byte.
// - signed and unsigned 32/16 and 16/16 division, matched signedness.
// - divide puts quotient in work_reg_zero, remainder in work_reg_one.
// - divisor any register; 32-bit dividend an even pair, odd holds upper.
// - divider iterates once per divisor bit, same time for both sizes.
// - both single-bit shifts and single-cycle multi-bit shifts exist.
// - barrel shifter moves up to 15 places in one cycle.
// - multi-bit shifts take and give working registers only, never memory.
// - shifts are arithmetic right, left and logical right, one or more places.
// - digit carry is carry out of bit 3 for bytes, bit 7 for words.
// - a divide keeps busy_o high for 21 cycles.
`include "camds_defines.svh"
`default_nettype none
module camds_top
  import camds_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // core status
  output logic             busy_o,
  output logic      [15:0] status_word_o
);

  logic [15:0]  wreg [16];
  camds_ctl_t   ctl;
  camds_state_t state;
  camds_state_t next_state;
  camds_flags_t flags;
  camds_flags_t nf;
  logic [15:0]  mem_op;
  logic [15:0]  mem_res;
  logic [15:0]  mem_res_hi;
  logic         illegal;

  logic         bus_req;
  logic         bus_wr;
  logic [15:0]  wmask;
  logic [31:0]  rd_mux;
  logic         go;

  logic [15:0]  a_raw;
  logic [15:0]  b_raw;
  logic [15:0]  msk;
  logic [15:0]  opa;
  logic [15:0]  opb;
  logic [15:0]  bx;
  logic [15:0]  ext;
  logic [15:0]  res;
  logic [15:0]  res_hi;
  logic         cin;
  logic         is_sub;
  logic         is_shift;
  logic         known;
  logic         multi_mem;
  logic         wr_res;
  logic         wr_pair;
  logic         upd_flags;
  logic [16:0]  sum17;
  logic [8:0]   dsum9;
  logic [4:0]   dsum5;
  logic [3:0]   cnt;
  logic [3:0]   lo_idx;
  logic [3:0]   hi_idx;
  logic [31:0]  prod;
  logic [31:0]  dvd;
  logic         div_start;
  logic         div_done;
  logic         div_ovf;
  logic [15:0]  div_quo;
  logic [15:0]  div_rem;

  function automatic logic sz_msb(input logic [15:0] v, input logic b);
    sz_msb = b ? v[7] : v[15];
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [15:0] m);
    merge16 = (old & ~m) | (nw & m);
  endfunction

  // bus handshake
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr  = bus_req & wb_we_i & wb_ack_o;
  assign wmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign go      = bus_wr && (wb_adr_i == `CAMDS_ADR_CTRL) && (state == st_idle);

  assign status_word_o = {7'h00, flags.digit_carry_flag, 4'h0, flags.n, flags.overflow_flag,
                          flags.z, flags.c};

  always_comb begin
    case (wb_adr_i)
      `CAMDS_ADR_CTRL:       rd_mux = {3'h0, ctl};
      `CAMDS_ADR_MEM_OP:     rd_mux = {16'h0000, mem_op};
      `CAMDS_ADR_MEM_RES:    rd_mux = {16'h0000, mem_res};
      `CAMDS_ADR_MEM_RES_HI: rd_mux = {16'h0000, mem_res_hi};
      `CAMDS_ADR_STATUS:     rd_mux = {16'h0000, status_word_o};
      `CAMDS_ADR_STATE:      rd_mux = {30'h00000000, illegal, busy_o};
      default: begin
        if ((wb_adr_i[7:6] == `CAMDS_WREG_WIN) && (wb_adr_i[1:0] == 2'h0)) begin
          rd_mux = {16'h0000, wreg[wb_adr_i[5:2]]};
        end else begin
          rd_mux = 32'h00000000;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req && !wb_ack_o) begin
      wb_dat_o <= rd_mux;
    end
  end

  // operand fetch and single-cycle datapath
  assign lo_idx = {ctl.d_idx[3:1], 1'b0};
  assign hi_idx = {ctl.d_idx[3:1], 1'b1};

  always_comb begin
    a_raw    = ctl.a_mem ? mem_op : wreg[ctl.a_idx];
    b_raw    = wreg[ctl.b_idx];
    msk      = ctl.byte_sz ? 16'h00ff : 16'hffff;
    opa      = a_raw & msk;
    opb      = b_raw & msk;
    is_sub   = (ctl.op == op_sub) || (ctl.op == op_subb);
    is_shift = (ctl.op == left_shift_op) || (ctl.op == arith_right_shift_op) ||
               (ctl.op == logical_right_shift_op);
    bx       = is_sub ? (~opb & msk) : opb;
    case (ctl.op)
      op_addc: cin = flags.c;
      op_sub:  cin = 1'b1;
      op_subb: cin = flags.c;
      default: cin = 1'b0;
    endcase
    sum17   = {1'b0, opa} + {1'b0, bx} + {16'h0000, cin};
    dsum9   = {1'b0, opa[7:0]} + {1'b0, bx[7:0]} + {8'h00, cin};
    dsum5   = {1'b0, opa[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    cnt     = ctl.lit[3:0];
    ext     = ctl.byte_sz ? {{8{a_raw[7]}}, a_raw[7:0]} : a_raw;
    res     = 16'h0000;
    res_hi  = 16'h0000;
    wr_pair = 1'b0;
    known   = 1'b1;
    nf      = flags;
    case (ctl.op)
      op_add, op_addc, op_sub, op_subb: begin
        res   = sum17[15:0] & msk;
        nf.c                = ctl.byte_sz ? sum17[8] : sum17[16];
        nf.digit_carry_flag = ctl.byte_sz ? dsum5[4] : dsum9[8];
        nf.overflow_flag    = (sz_msb(opa, ctl.byte_sz) == sz_msb(bx, ctl.byte_sz)) &&
                              (sz_msb(res, ctl.byte_sz) != sz_msb(opa, ctl.byte_sz));
      end
      op_and: res = opa & opb;
      op_ior: res = opa | opb;
      op_xor: res = opa ^ opb;
      left_shift_op: begin
        res = (opa << cnt) & msk;
        if (cnt == 4'h1) begin
          nf.c = sz_msb(opa, ctl.byte_sz);
        end
      end
      arith_right_shift_op: begin
        res = 16'($signed(ext) >>> cnt) & msk;
        if (cnt == 4'h1) begin
          nf.c = opa[0];
        end
      end
      logical_right_shift_op: begin
        res = opa >> cnt;
        if (cnt == 4'h1) begin
          nf.c = opa[0];
        end
      end
      op_mul: begin
        res     = prod[15:0];
        res_hi  = prod[31:16];
        wr_pair = 1'b1;
      end
      op_div: ;
      default: known = 1'b0;
    endcase
    if (ctl.op != op_mul && ctl.op != op_div) begin
      nf.n = sz_msb(res, ctl.byte_sz);
      nf.z = ctl.byte_sz ? (res[7:0] == 8'h00) : (res == 16'h0000);
    end
  end

  assign multi_mem = is_shift && (cnt > 4'h1) && (ctl.a_mem || ctl.d_mem);
  assign wr_res    = (state == st_exec) && known && !multi_mem && (ctl.op != op_div);
  assign upd_flags = wr_res && (ctl.op != op_mul);

  camds_mul u_mul (
    .a_i    (opa),
    .b_i    (b_raw),
    .lit_i  (ctl.lit),
    .mode_i (ctl.mmode),
    .prod_o (prod)
  );

  // dividend from an even pair when div32, odd register holds the upper half; otherwise a_idx alone, extended
  always_comb begin
    if (ctl.div32) begin
      dvd = {wreg[{ctl.a_idx[3:1], 1'b1}], wreg[{ctl.a_idx[3:1], 1'b0}]};
    end else if (ctl.dsign) begin
      dvd = {{16{wreg[ctl.a_idx][15]}}, wreg[ctl.a_idx]};
    end else begin
      dvd = {16'h0000, wreg[ctl.a_idx]};
    end
  end

  assign div_start = (state == st_exec) && (ctl.op == op_div);

  camds_div u_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (div_start),
    .sign_i  (ctl.dsign),
    .dvd_i   (dvd),
    .dvs_i   (wreg[ctl.b_idx]),
    .done_o  (div_done),
    .ovf_o   (div_ovf),
    .quo_o   (div_quo),
    .rem_o   (div_rem)
  );

  // sequencing
  always_comb begin
    case (state)
      st_idle: next_state = go ? st_exec : st_idle;
      st_exec: next_state = div_start ? st_divw : st_idle;
      st_divw: next_state = div_done ? st_idle : st_divw;
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= st_idle;
      busy_o <= 1'b0;
    end else begin
      state  <= next_state;
      busy_o <= (next_state != st_idle);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl <= camds_ctl_t'(`CAMDS_RST_CTL);
    end else if (go) begin
      ctl <= camds_ctl_t'(wb_dat_i[28:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      illegal <= 1'b0;
    end else if (state == st_exec) begin
      illegal <= multi_mem | ~known;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_op <= `CAMDS_RST_WORD;
    end else if (bus_wr && (wb_adr_i == `CAMDS_ADR_MEM_OP)) begin
      mem_op <= merge16(mem_op, wb_dat_i[15:0], wmask);
    end
  end

  // memory-side result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_res    <= `CAMDS_RST_WORD;
      mem_res_hi <= `CAMDS_RST_WORD;
    end else if (wr_res && ctl.d_mem) begin
      if (wr_pair) begin
        mem_res    <= res;
        mem_res_hi <= res_hi;
      end else begin
        mem_res <= ctl.byte_sz ? {mem_res[15:8], res[7:0]} : res;
      end
    end
  end

  // working register array; datapath writes win over the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        wreg[i] <= `CAMDS_RST_WORD;
      end
    end else if ((state == st_divw) && div_done) begin
      wreg[0] <= div_quo;
      wreg[1] <= div_rem;
    end else if (wr_res && !ctl.d_mem) begin
      if (wr_pair) begin
        wreg[lo_idx] <= res;
        wreg[hi_idx] <= res_hi;
      end else if (ctl.byte_sz) begin
        wreg[ctl.d_idx] <= {wreg[ctl.d_idx][15:8], res[7:0]};
      end else begin
        wreg[ctl.d_idx] <= res;
      end
    end else if (bus_wr && (wb_adr_i[7:6] == `CAMDS_WREG_WIN) && (wb_adr_i[1:0] == 2'h0)) begin
      wreg[wb_adr_i[5:2]] <= merge16(wreg[wb_adr_i[5:2]], wb_dat_i[15:0], wmask);
    end
  end

  // status word; hardware update wins over a software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags <= '0;
    end else if (upd_flags) begin
      flags <= nf;
    end else if ((state == st_divw) && div_done) begin
      flags.n             <= div_quo[15];
      flags.z             <= (div_quo == 16'h0000);
      flags.overflow_flag <= div_ovf;
    end else if (bus_wr && (wb_adr_i == `CAMDS_ADR_STATUS)) begin
      if (wb_sel_i[0]) begin
        flags.n             <= wb_dat_i[`CAMDS_SW_N];
        flags.overflow_flag <= wb_dat_i[`CAMDS_SW_OVERFLOW];
        flags.z             <= wb_dat_i[`CAMDS_SW_Z];
        flags.c             <= wb_dat_i[`CAMDS_SW_C];
      end
      if (wb_sel_i[1]) begin
        flags.digit_carry_flag <= wb_dat_i[`CAMDS_SW_DIGIT_CARRY];
      end
    end
  end

endmodule
`default_nettype wire

// [verif/camds_host.sv]
`default_nettype none
module camds_host (
  // clock and answer
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  // request
  output var  logic        cyc_o,
  output var  logic        stb_o,
  output var  logic        we_o,
  output var  logic [7:0]  adr_o,
  output var  logic [3:0]  sel_o,
  output var  logic [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  // one classic cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

// [verif/camds_props.sv]
`default_nettype none
module camds_props (
  // bus, busy and flags
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        busy_o,
  input wire logic [15:0] status_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic       req;
  logic       wr_ctl;
  logic       wr_st;
  logic [5:0] bcnt;
  assign req    = wb_cyc_i && wb_stb_i;
  assign wr_ctl = req && wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && !busy_o;
  assign wr_st  = req && wb_ack_o && wb_we_i && wb_adr_i == 8'h10;
  // length of the current busy run
  always_ff @(posedge clk_i)
    if (rst_i || !busy_o)
      bcnt <= 6'h0;
    else
      bcnt <= bcnt + 6'h1;
  a_ack_follows: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_op_single: assert property (wr_ctl && wb_dat_i[3:0] < 4'hb && wb_dat_i[14:13] == 2'h0
    |=> busy_o ##1 !busy_o) else $error("single cycle op not done in one cycle");
  a_div_time: assert property (wr_ctl && wb_dat_i[3:0] == 4'hb
    |=> ##21 (!busy_o && bcnt == 6'h15)) else $error("divide length wrong");
  a_flags_hold: assert property ($changed(status_word_o)
    |-> $past(busy_o) || $past(wr_st) || $past(rst_i)) else $error("flags moved while idle");
  a_status_unused: assert property (status_word_o[15:9] == 7'h0 && status_word_o[7:4] == 4'h0)
    else $error("unused status bits set");
  a_busy_start: assert property ($rose(busy_o) |-> $past(wr_ctl))
    else $error("busy without control write");
  a_upper_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:6] == 2'h1
    |-> wb_dat_o[31:16] == 16'h0) else $error("work reg upper half not zero");
  c_div: cover property (wr_ctl && wb_dat_i[3:0] == 4'hb);
  c_mul: cover property (wr_ctl && wb_dat_i[3:0] == 4'ha);
  c_flags: cover property ($changed(status_word_o) && !$past(wr_st));
endmodule
bind camds_top camds_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o), .status_word_o(status_word_o));
`default_nettype wire

// [verif/testbench.sv]
`default_nettype none
module testbench
  import camds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, cyc, stb, we, ack, busy, bt;
  logic [7:0]  adr;
  logic [3:0]  sel, op, n;
  logic [4:0]  f;
  logic [15:0] sw_o, a, b, d;
  logic [20:0] e;
  logic [31:0] dat_w, dat_r, rnd, sw;
  logic [31:0] exp_q[$];
  logic signed [16:0] x, y;
  logic signed [33:0] p;
  logic [31:0] dvd_t[4] = '{32'h0001e240, 32'hfff0bdc0, 32'h5a5afff0, 32'h1234ff9c};
  logic [15:0] dvs_t[4] = '{16'h03e8, 16'h012c, 16'h0007, 16'h0007};
  camds_ctl_t  c;
  int          n_mismatch, comparisons, qd, qv;
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
  end
  camds_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .busy_o(busy), .status_word_o(sw_o));
  camds_host host (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(dat_w));
  task automatic check(input logic [7:0] r, input logic [31:0] seen, input logic [31:0] ex);
    comparisons++;
    if (seen !== ex) begin
      n_mismatch++;
      $display("BAD reg_%h expected %h seen %h", r, ex, seen);
    end
  endtask
  // read results against the oldest note
  always @(posedge clk_i)
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      check(adr, dat_r, exp_q.pop_front());
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    print_verdict();
  end
  function automatic logic [15:0] nx();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd[15:0];
  endfunction
  function automatic logic [7:0] wa(input logic [3:0] i);
    return {2'h1, i, 2'h0};
  endfunction
  function automatic logic [31:0] fl2sw(input logic [4:0] g);
    return {23'h0, g[4], 4'h0, g[3:0]};
  endfunction
  // expected {digit carry, n, overflow, z, c, destination word}
  function automatic logic [20:0] ref_alu(input logic [3:0] o, input logic bw,
      input logic [15:0] s1, s2, ds, input logic [4:0] g0, input logic [3:0] k);
    logic [15:0] m, xa, xb, r;
    logic [16:0] s;
    logic [4:0]  g;
    logic        ci;
    int          t;
    t = bw ? 7 : 15;
    m = bw ? 16'h00ff : 16'hffff;
    xa = s1 & m;
    xb = ((o == 4'h2 || o == 4'h3) ? ~s2 : s2) & m;
    ci = (o == 4'h1 || o == 4'h3) ? g0[0] : (o == 4'h2);
    s = xa + xb + ci;
    g = g0;
    case (o)
      4'h4: r = s1 & s2;
      4'h5: r = s1 | s2;
      4'h6: r = s1 ^ s2;
      4'h7: r = s1 << k;
      4'h8: r = $signed(s1) >>> k;
      4'h9: r = s1 >> k;
      default: begin
        r = s[15:0];
        g[0] = s[t+1];
        g[4] = bw ? ((xa[3:0] + xb[3:0] + ci) > 15) : ((xa[7:0] + xb[7:0] + ci) > 255);
        g[2] = (xa[t] == xb[t]) && (r[t] != xa[t]);
      end
    endcase
    if (o > 4'h6 && k == 4'h1)
      g[0] = (o == 4'h7) ? s1[15] : s1[0];
    g[3] = r[t];
    g[1] = ((r & m) == 16'h0);
    return {g, bw ? {ds[15:8], r[7:0]} : r};
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    host.xfer(1'b1, ad, v);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] v);
    exp_q.push_back(v);
    host.xfer(1'b0, ad, 32'h0);
  endtask
  task automatic run(input camds_ctl_t cw);
    int k;
    wr(8'h00, {3'h0, cw});
    @(posedge clk_i);
    check(8'h14, {31'h0, busy}, 32'h1);
    k = 0;
    while (busy === 1'b1 && k < 40) begin
      @(posedge clk_i);
      k++;
    end
    check(8'h14, 32'(k), (cw.op == op_div) ? 32'h15 : 32'h1);
  endtask
  initial begin
    rnd = 32'h2eb4;
    c = '0;
    c.a_idx = 4'h1;
    c.b_idx = 4'h2;
    c.d_idx = 4'h3;
    repeat (18) @(posedge clk_i);
    rd(8'h10, 32'h0);
    rd(wa(4'h5), 32'h0);
    for (int i = 0; i < 36; i++) begin
      op = (i < 20) ? 4'(i % 7) : 4'(7 + i % 3);
      n = (i % 4 == 0) ? 4'h0 : (i % 4 == 1) ? 4'h1 : (i % 4 == 2) ? 4'hf : 4'(nx());
      bt = (i < 20) && i[1];
      a = (i % 5 == 0) ? 16'h7fff : nx();
      b = (i % 5 == 0) ? 16'h0001 : nx();
      d = nx();
      f = 5'(nx());
      c.op = camds_op_t'(op);
      c.byte_sz = bt;
      c.lit = {1'b0, n};
      wr(wa(4'h1), {16'h0, a});
      wr(wa(4'h2), {16'h0, b});
      wr(wa(4'h3), {16'h0, d});
      wr(8'h10, fl2sw(f));
      run(c);
      e = ref_alu(op, bt, a, b, d, f, n);
      sw = fl2sw(e[20:16]);
      check(8'h10, {16'h0, sw_o}, sw);
      rd(wa(4'h3), {16'h0, e[15:0]});
      rd(8'h10, sw);
    end
    c.op = arith_right_shift_op;
    c.lit = 5'h03;
    c.a_mem = 1'b1;
    wr(wa(4'h3), 32'h1234);
    run(c);
    rd(wa(4'h3), 32'h1234);
    rd(8'h10, sw);
    rd(8'h14, 32'h2);
    c.op = op_add;
    c.d_mem = 1'b1;
    wr(8'h04, 32'h8001);
    wr(wa(4'h2), 32'h0002);
    run(c);
    rd(8'h08, 32'h8003);
    rd(8'h14, 32'h0);
    sw = 32'h8;
    rd(8'h10, sw);
    c.a_mem = 1'b0;
    c.d_mem = 1'b0;
    c.op = op_mul;
    c.d_idx = 4'h5;
    for (int m = 0; m < 6; m++) begin
      a = nx();
      b = nx();
      c.lit = 5'(nx());
      c.mmode = camds_mmode_t'(m);
      wr(wa(4'h1), {16'h0, a});
      wr(wa(4'h2), {16'h0, b});
      run(c);
      x = (m == 5) ? {9'h0, a[7:0]} : {(m == 0 || m == 2) & a[15], a};
      y = (m == 2 || m == 3) ? {12'h0, c.lit} : (m == 5) ? {9'h0, b[7:0]}
        : {(m == 0 || m == 4) & b[15], b};
      p = x * y;
      rd(wa(4'h4), {16'h0, p[15:0]});
      rd(wa(4'h5), {16'h0, p[31:16]});
      rd(8'h10, sw);
    end
    c.op = op_div;
    c.a_idx = 4'h6;
    for (int k = 0; k < 4; k++) begin
      c.dsign = k[0];
      c.div32 = (k < 2);
      wr(wa(4'h6), {16'h0, dvd_t[k][15:0]});
      wr(wa(4'h7), {16'h0, dvd_t[k][31:16]});
      wr(wa(4'h2), {16'h0, dvs_t[k]});
      run(c);
      qd = (k < 2) ? int'(dvd_t[k]) : k[0] ? int'($signed(dvd_t[k][15:0])) : int'(dvd_t[k][15:0]);
      qv = k[0] ? int'($signed(dvs_t[k])) : int'(dvs_t[k]);
      rd(wa(4'h0), {16'h0, 16'(qd / qv)});
      rd(wa(4'h1), {16'h0, 16'(qd % qv)});
    end
    @(posedge clk_i);
    if (exp_q.size() != 0)
      n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
